/* File: hdl/irq_priority_pick.sv */
// lowest numbered pending line finder
`timescale 1ns/1ps
module irq_priority_pick (
  irq_arb_if.picker arb
);
  import irq_wake_pkg::*;

  // ==========================================================
  // scan from the top so the lowest set line wins last
  always_comb begin
    arb.found = 1'b0;
    arb.index = '0;
    for (int i = NUM_LINES - 1; i >= 0; i--) begin
      if (arb.pending[i]) begin
        arb.found = 1'b1; // R15
        arb.index = LINE_W'(i); // R15
      end
    end
  end
endmodule // irq_priority_pick

/* File: hdl/irq_wake_ctrl.sv */
// interrupt vector, low-power state and clock gating controller
`timescale 1ns/1ps
module irq_wake_ctrl (
  input  wire logic                                clock,
  input  wire logic                                rst_b,
  input  wire logic [irq_wake_pkg::NUM_LINES-1:0]  irq_req,
  input  wire logic [irq_wake_pkg::NUM_LINES-1:0]  irq_enable,
  input  wire logic                                trap_req,
  input  wire logic                                vec_ack,
  input  wire logic                                lowpower_req,
  input  wire irq_wake_pkg::mode_type              lowpower_sel,
  input  wire logic                                periph_keep_in_wait,
  input  wire logic [irq_wake_pkg::PRESC_W-1:0]    presc_sel,
  input  wire logic                                slow_osc_tick,
  input  wire logic                                auto_wakeup_en,
  input  wire logic [irq_wake_pkg::WAKEUP_W-1:0]   auto_wakeup_period,
  input  wire logic                                watchdog_en,
  input  wire logic                                watchdog_kick,
  output logic                                     vec_valid,
  output logic [irq_wake_pkg::VEC_W-1:0]           vec_addr,
  output logic [irq_wake_pkg::LINE_W-1:0]          vec_line,
  output logic                                     cpu_clk_en,
  output logic                                     periph_clk_en,
  output logic                                     sys_clk_tick,
  output logic                                     lowpower_regulator_mode,
  output irq_wake_pkg::mode_type                   mode_state,
  output logic                                     watchdog_reset_req
);
  import irq_wake_pkg::*;

  irq_arb_if arb ();

  mode_type             mode_reg;
  logic                 vec_valid_reg;
  logic [VEC_W-1:0]     vec_addr_reg;
  logic [LINE_W-1:0]    vec_line_reg;
  logic                 boot_reg;
  logic                 trap_pend_reg;
  logic                 cpu_clk_en_reg;
  logic                 periph_clk_en_reg;
  logic                 lp_reg;
  logic [PRESC_W+3:0]   presc_cnt_reg;
  logic                 sys_tick_reg;
  logic [WAKEUP_W-1:0]  wakeup_cnt_reg;
  logic                 wakeup_flag_reg;
  logic [WDG_W-1:0]     wdg_cnt_reg;
  logic                 wdg_req_reg;
  logic [NUM_LINES-1:0] raw_lines;
  logic [NUM_LINES-1:0] pending;
  logic                 wake;
  logic                 wakeup_hit;
  logic                 line_taken;

  // ==========================================================
  // line gathering
  always_comb begin
    raw_lines           = irq_req;
    raw_lines[WAKEUP_LINE] = irq_req[WAKEUP_LINE] | wakeup_flag_reg; // R10
  end
  // reserved slots are masked off so they can never be picked or wake
  assign pending     = raw_lines & irq_enable & ~RESERVED_MASK; // R14
  assign arb.pending = pending;
  assign line_taken  = mode_reg == MODE_RUN && !vec_valid_reg && !boot_reg
                       && !trap_pend_reg && arb.found;

  irq_priority_pick u_pick (
    .arb (arb)
  );

  // ==========================================================
  // wake decision per state
  always_comb begin
    case (mode_reg)
      MODE_WAIT:        wake = |pending; // R12 R13
      MODE_ACTIVE_HALT: wake = |(pending & AHALT_WAKE_MASK); // R2 R10
      MODE_HALT:        wake = |(pending & HALT_WAKE_MASK); // R3 R11
      default:          wake = 1'b0;
    endcase
  end

  // ==========================================================
  // low-power state machine; synchronous reset returns to run from any state
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mode_reg <= MODE_RUN; // R9
    end else begin
      case (mode_reg)
        MODE_RUN: begin
          if (lowpower_req && lowpower_sel != MODE_RUN) begin
            mode_reg <= lowpower_sel;
          end
        end
        MODE_WAIT, MODE_ACTIVE_HALT, MODE_HALT: begin
          if (wake) begin
            mode_reg <= MODE_RUN;
          end
        end
        default: mode_reg <= MODE_RUN;
      endcase
    end
  end

  // ==========================================================
  // clock gates and regulator
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cpu_clk_en_reg    <= 1'b1;
      periph_clk_en_reg <= 1'b1;
      lp_reg            <= 1'b0;
    end else begin
      cpu_clk_en_reg    <= mode_reg == MODE_RUN; // R1 R6
      periph_clk_en_reg <= mode_reg == MODE_RUN
                           || (mode_reg == MODE_WAIT && periph_keep_in_wait); // R1 R2 R3 R6
      lp_reg            <= mode_reg == MODE_HALT
                           || mode_reg == MODE_ACTIVE_HALT; // R4
    end
  end

  // ==========================================================
  // system clock prescaler: 2^presc_sel division of the core rate
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      presc_cnt_reg <= '0;
      sys_tick_reg  <= 1'b0;
    end else begin
      if (presc_cnt_reg >= (PRESC_W+4)'((1 << presc_sel) - 1)) begin
        presc_cnt_reg <= '0;
        sys_tick_reg  <= 1'b1; // R5
      end else begin
        presc_cnt_reg <= presc_cnt_reg + 1'b1;
        sys_tick_reg  <= 1'b0;
      end
    end
  end

  // ==========================================================
  // auto-wakeup timer on slow oscillator ticks
  assign wakeup_hit = auto_wakeup_en && slow_osc_tick
                      && wakeup_cnt_reg >= auto_wakeup_period;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wakeup_cnt_reg <= WAKEUP_CNT_INIT;
    end else if (!auto_wakeup_en || wakeup_hit) begin
      wakeup_cnt_reg <= WAKEUP_CNT_INIT;
    end else if (slow_osc_tick) begin
      wakeup_cnt_reg <= wakeup_cnt_reg + 1'b1; // R7
    end
  end
  // a new expiry in the acknowledge cycle is kept
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wakeup_flag_reg <= 1'b0;
    end else if (wakeup_hit) begin
      wakeup_flag_reg <= 1'b1; // R2
    end else if (vec_valid_reg && vec_ack && vec_line_reg == WAKEUP_LINE
                 && vec_addr_reg != TRAP_VEC && vec_addr_reg != RESET_VEC) begin
      wakeup_flag_reg <= 1'b0;
    end
  end

  // ==========================================================
  // watchdog, deliberately blind to the processor clock gate
  // an expiry beats a kick in the same cycle, so a late kick cannot hide it
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wdg_cnt_reg <= '0;
      wdg_req_reg <= 1'b0;
    end else if (!watchdog_en) begin
      wdg_cnt_reg <= '0;
      wdg_req_reg <= 1'b0;
    end else if (slow_osc_tick && wdg_cnt_reg == WDG_TIMEOUT_DEF && !wdg_req_reg) begin
      wdg_req_reg <= 1'b1; // R8
    end else if (watchdog_kick) begin
      wdg_cnt_reg <= '0;
      wdg_req_reg <= 1'b0;
    end else if (slow_osc_tick && wdg_cnt_reg != WDG_TIMEOUT_DEF) begin
      wdg_cnt_reg <= wdg_cnt_reg + 1'b1; // R7 R8
    end
  end

  // ==========================================================
  // vector presentation: reset first, then trap, then lowest line
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      trap_pend_reg <= 1'b0;
    end else if (trap_req) begin
      trap_pend_reg <= 1'b1;
    end else if (mode_reg == MODE_RUN && !vec_valid_reg && !boot_reg) begin
      trap_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      boot_reg      <= 1'b1;
      vec_valid_reg <= 1'b0;
      vec_addr_reg  <= RESET_VEC;
      vec_line_reg  <= '0;
    end else if (vec_valid_reg) begin
      if (vec_ack) begin
        vec_valid_reg <= 1'b0;
      end
    end else if (boot_reg) begin
      boot_reg      <= 1'b0;
      vec_valid_reg <= 1'b1;
      vec_addr_reg  <= RESET_VEC; // R9
    end else if (mode_reg == MODE_RUN && trap_pend_reg) begin
      vec_valid_reg <= 1'b1;
      vec_addr_reg  <= TRAP_VEC; // R9
    end else if (line_taken) begin
      vec_valid_reg <= 1'b1;
      vec_line_reg  <= arb.index; // R15
      vec_addr_reg  <= LINE_VEC_BASE + {17'h00000, arb.index, 2'b00}; // R14
    end
  end

  // ==========================================================
  // outputs
  assign vec_valid               = vec_valid_reg;
  assign vec_addr                = vec_addr_reg;
  assign vec_line                = vec_line_reg;
  assign cpu_clk_en              = cpu_clk_en_reg;
  assign periph_clk_en           = periph_clk_en_reg;
  assign sys_clk_tick            = sys_tick_reg;
  assign lowpower_regulator_mode = lp_reg;
  assign mode_state              = mode_reg;
  assign watchdog_reset_req      = wdg_req_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_wait_cpu_gate: assert property (mode_reg == MODE_WAIT && periph_keep_in_wait // R1
    |=> !cpu_clk_en && periph_clk_en) else $error("wait gating wrong");
  a_halt_all_stop: assert property (mode_reg == MODE_HALT || mode_reg == MODE_ACTIVE_HALT // R3
    |=> !cpu_clk_en && !periph_clk_en) else $error("halt gating wrong");
  a_regulator_low: assert property ($rose(mode_reg == MODE_HALT) // R4
    |=> lowpower_regulator_mode) else $error("regulator not low in halt");
  a_halt_exit_pin: assert property (mode_reg == MODE_HALT ##1 mode_reg == MODE_RUN // R3
    |-> $past(|(pending & HALT_WAKE_MASK))) else $error("halt left without pin line");
  a_timer_wakes_ah: assert property (mode_reg == MODE_ACTIVE_HALT && wakeup_hit // R2
    |-> ##[1:2] mode_reg == MODE_RUN) else $error("auto-wakeup did not end active-halt");
  a_vector_spacing: assert property ($rose(vec_valid) && vec_addr != RESET_VEC // R14
    && vec_addr != TRAP_VEC |-> vec_addr == LINE_VEC_BASE + {17'h00000, vec_line, 2'b00}
    && !RESERVED_MASK[vec_line]) else $error("bad line vector");
  a_lowest_first: assert property (line_taken // R15
    |=> !(|($past(pending) & ((27'h0000001 << vec_line) - 27'h0000001))))
    else $error("higher line presented first");
  a_reset_vector: assert property ($rose(rst_b) |=> vec_valid && vec_addr == RESET_VEC) // R9
    else $error("reset vector not presented");
  a_watchdog_runs: assert property (watchdog_en && !watchdog_kick && slow_osc_tick // R8
    && !cpu_clk_en && wdg_cnt_reg < WDG_TIMEOUT_DEF |=> wdg_cnt_reg == $past(wdg_cnt_reg) + 1'b1)
    else $error("watchdog stalled with cpu clock off");
  a_wait_only_no: assert property (mode_reg == MODE_HALT && !(|(pending & HALT_WAKE_MASK)) // R12
    |=> mode_reg == MODE_HALT) else $error("halt ended by wait-only line");
endmodule // irq_wake_ctrl

/* File: include/irq_arb_if.sv */
// carrier between the controller and its priority picker
`timescale 1ns/1ps
interface irq_arb_if;
  import irq_wake_pkg::*;
  logic [NUM_LINES-1:0] pending;
  logic                 found;
  logic [LINE_W-1:0]    index;
  modport picker (input pending, output found, index);
  modport user   (output pending, input found, index);
endinterface

/* File: include/irq_wake_pkg.sv */
// constants and types for the interrupt vector and wakeup controller
// What this block does
// R1 - wait stops the processor clock, selected peripherals keep running
// R2 - active-halt stops all clocks, auto-wakeup timer ends it after its interval
// R3 - halt stops all clocks, only external pin lines or reset end it
// R4 - both halt states switch the core supply to low-power regulator mode
// R5 - system clock comes from fast oscillator through a programmable prescaler
// R6 - core and peripheral clock gates follow the current low-power state
// R7 - slow oscillator ticks drive auto-wakeup timer and watchdog only
// R8 - watchdog keeps counting while the processor clock is stopped
// R9 - reset vectors to 0x008000 and ends any state, trap to 0x008004
// R10 - auto-wakeup is line 4 at 0x008018, ends active-halt and wait
// R11 - port and pin lines 6 to 15 end halt, active-halt and wait
// R12 - flash done line 1 and comparator line 18 end wait only
// R13 - timer lines 19 to 22 and 25 vector in order and end wait only
// R14 - vectors sit four bytes apart, reserved lines never raise nor wake
// R15 - lowest numbered pending enabled line is presented first
package irq_wake_pkg;
  // ==========================================================
  // sizes
  localparam int NUM_LINES  = 27;
  localparam int LINE_W     = 5;
  localparam int VEC_W      = 24;
  localparam int WAKEUP_W   = 12;
  localparam int WDG_W      = 12;
  localparam int PRESC_W    = 3;
  // ==========================================================
  // vectors
  localparam logic [VEC_W-1:0] RESET_VEC     = 24'h008000;
  localparam logic [VEC_W-1:0] TRAP_VEC      = 24'h008004;
  localparam logic [VEC_W-1:0] LINE_VEC_BASE = 24'h008008;
  // ==========================================================
  // line maps
  // lines 0, 2, 3, 5, 16, 17, 23 and 24 are empty slots
  localparam logic [NUM_LINES-1:0] RESERVED_MASK   = 27'h183002D;
  localparam logic [NUM_LINES-1:0] HALT_WAKE_MASK  = 27'h000FFC0;
  localparam logic [NUM_LINES-1:0] AHALT_WAKE_MASK = 27'h000FFD0;
  localparam logic [LINE_W-1:0]    WAKEUP_LINE     = 5'h04;
  // ==========================================================
  // clocks and timing
  localparam int FAST_OSC_KHZ = 16000;
  localparam int SLOW_OSC_KHZ = 38;
  localparam logic [WDG_W-1:0]   WDG_TIMEOUT_DEF = 12'hFFF;
  localparam logic [WAKEUP_W-1:0] WAKEUP_CNT_INIT = 12'h000;
  localparam logic [PRESC_W-1:0] PRESC_RESET     = 3'h0;
  // ==========================================================
  // states
  typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_ACTIVE_HALT, MODE_HALT} mode_type;
endpackage

/* File: tb/cpu_vector_model.sv */
// processor side model that fetches and acknowledges presented vectors
`timescale 1ns/1ps
module cpu_vector_model (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic vec_valid,
  input  wire logic [3:0] ack_delay,
  output logic      vec_ack
);
  // ==========================================================
  // acknowledge
  logic [3:0] wait_reg;
  // ack is held until the edge that samples it, then dropped so one fetch acks once
  always_ff @(posedge clock) begin
    if (!rst_b || !vec_valid || vec_ack) begin
      vec_ack  <= 1'b0;
      wait_reg <= 4'h0;
    end else if (wait_reg == ack_delay) begin
      vec_ack <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule // cpu_vector_model

/* File: tb/test_interrupt_vector_wakeup_control.sv */
// testbench for the interrupt vector and wakeup controller
`timescale 1ns/1ps
module test_interrupt_vector_wakeup_control;
  import irq_wake_pkg::*;
  typedef struct packed {logic [4:0] line; mode_type mode; logic keep;} row_type;
  // ==========================================================
  // stimulus and wiring
  logic clock = 0, rst_b = 0, trap = 0, lp_req = 0, keep = 0, tick = 0;
  logic wake_en = 0, wdg_en = 0, kick = 0, vec_ack, vec_valid, cpu_en, per_en, stick, reg_lp, wdr;
  logic [26:0] irq = '0, irq_en = '1;
  logic [2:0] presc = 3'h0;
  logic [11:0] wake_per = 12'h003;
  logic [3:0] ack_delay = 4'h0, tick_cnt = 4'h0;
  logic [23:0] vec_addr;
  logic [4:0] vec_line;
  mode_type sel = MODE_RUN, mode_state;
  int errors = 0, n_checks = 0, i, n;
  row_type rows[$] = '{'{5'd1, MODE_WAIT, 1'b1}, '{5'd18, MODE_WAIT, 1'b0},
    '{5'd19, MODE_WAIT, 1'b1}, '{5'd20, MODE_WAIT, 1'b0}, '{5'd21, MODE_WAIT, 1'b1},
    '{5'd22, MODE_WAIT, 1'b0}, '{5'd25, MODE_WAIT, 1'b1}, '{5'd26, MODE_WAIT, 1'b0},
    '{5'd4, MODE_WAIT, 1'b1}, '{5'd4, MODE_ACTIVE_HALT, 1'b0}, '{5'd7, MODE_ACTIVE_HALT, 1'b0},
    '{5'd1, MODE_ACTIVE_HALT, 1'b0}, '{5'd19, MODE_ACTIVE_HALT, 1'b0}, '{5'd6, MODE_HALT, 1'b0},
    '{5'd15, MODE_HALT, 1'b0}, '{5'd4, MODE_HALT, 1'b0}, '{5'd18, MODE_HALT, 1'b0},
    '{5'd25, MODE_HALT, 1'b0}};
  always #12.5 clock = ~clock;
  // slow oscillator stand-in: one pulse every 8 core cycles
  always @(negedge clock) begin
    tick_cnt <= tick_cnt + 4'h1;
    tick <= (tick_cnt[2:0] == 3'h7);
  end
  irq_wake_ctrl dut_u (.clock(clock), .rst_b(rst_b), .irq_req(irq), .irq_enable(irq_en),
    .trap_req(trap), .vec_ack(vec_ack), .lowpower_req(lp_req), .lowpower_sel(sel),
    .periph_keep_in_wait(keep), .presc_sel(presc), .slow_osc_tick(tick),
    .auto_wakeup_en(wake_en), .auto_wakeup_period(wake_per), .watchdog_en(wdg_en),
    .watchdog_kick(kick), .vec_valid(vec_valid), .vec_addr(vec_addr), .vec_line(vec_line),
    .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .sys_clk_tick(stick),
    .lowpower_regulator_mode(reg_lp), .mode_state(mode_state), .watchdog_reset_req(wdr));
  cpu_vector_model cpu_u (.clock(clock), .rst_b(rst_b), .vec_valid(vec_valid),
    .ack_delay(ack_delay), .vec_ack(vec_ack));
  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic wakes(input int l, input mode_type m);
    if (m == MODE_HALT) return l >= 6 && l <= 15;
    if (m == MODE_ACTIVE_HALT) return l == 4 || (l >= 6 && l <= 15);
    return 1'b1;
  endfunction
  // clears only the presented source, so a later pending line stays up
  task automatic take_vec(input logic [23:0] exp);
    int k;
    for (k = 0; k < 100 && vec_valid !== 1'b1; k++) @(negedge clock);
    chk("vec_addr", exp, vec_addr);
    if (exp >= 24'h008008) begin
      chk("vec_line", (exp - 24'h008008) >> 2, 24'(vec_line));
      irq[vec_line] = 1'b0;
    end
    for (k = 0; k < 30 && vec_valid !== 1'b0; k++) @(negedge clock);
    chk("vec_done", 24'h0, 24'(vec_valid));
  endtask
  task automatic enter(input mode_type m);
    lp_req = 1'b1;
    sel = m;
    @(negedge clock);
    lp_req = 1'b0;
    repeat (2) @(negedge clock);
    chk("mode", 24'(m), 24'(mode_state));
    chk("cpu_en", 24'h0, 24'(cpu_en));
    chk("per_en", 24'(m == MODE_WAIT && keep), 24'(per_en));
    chk("reg_lp", 24'(m != MODE_WAIT), 24'(reg_lp));
  endtask
  task automatic do_reset();
    rst_b = 1'b0;
    repeat (12) @(negedge clock);
    chk("rst_cpu_en", 24'h1, 24'(cpu_en));
    chk("rst_mode", 24'(MODE_RUN), 24'(mode_state));
    rst_b = 1'b1;
    take_vec(RESET_VEC);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #(25ns * 80000);
    errors++;
    test_done();
  end
  // ==========================================================
  // sequence
  initial begin
    @(negedge clock);
    do_reset();
    foreach (rows[r]) begin
      ack_delay = 4'(r % 4);
      keep = rows[r].keep;
      enter(rows[r].mode);
      irq[rows[r].line] = 1'b1;
      repeat (6) @(negedge clock);
      if (wakes(rows[r].line, rows[r].mode)) begin
        take_vec(24'h008008 + 24'(4 * rows[r].line));
      end else begin
        chk("stay", 24'(rows[r].mode), 24'(mode_state));
        irq = '0;
        irq[6] = 1'b1;
        take_vec(24'h008020);
      end
    end
    irq = RESERVED_MASK;
    repeat (10) @(negedge clock);
    chk("reserved", 24'h0, 24'(vec_valid));
    irq = 27'h2000280;
    take_vec(24'h008024);
    take_vec(24'h00802C);
    take_vec(24'h00806C);
    // a disabled lower line must be skipped and never presented
    irq_en[8] = 1'b0;
    irq[9:8] = 2'b11;
    take_vec(24'h00802C);
    repeat (5) @(negedge clock);
    chk("masked", 24'h0, 24'(vec_valid));
    irq[8] = 1'b0;
    irq_en = '1;
    trap = 1'b1;
    @(negedge clock);
    trap = 1'b0;
    take_vec(TRAP_VEC);
    for (i = 0; i < 4; i++) begin
      presc = 3'(i);
      n = 0;
      repeat (64) begin
        @(negedge clock);
        n += int'(stick === 1'b1);
      end
      chk("ticks", 24'(64 >> i), 24'(n));
    end
    wake_en = 1'b1;
    enter(MODE_ACTIVE_HALT);
    take_vec(24'h008018);
    wake_en = 1'b0;
    wdg_en = 1'b1;
    enter(MODE_HALT);
    // a kick halfway restarts the count; without it the request would be up by now
    repeat (16000) @(negedge clock);
    kick = 1'b1;
    @(negedge clock);
    kick = 1'b0;
    repeat (32000) @(negedge clock);
    chk("wdg_kicked", 24'h0, 24'(wdr));
    repeat (1000) @(negedge clock);
    chk("wdg_fire", 24'h1, 24'(wdr));
    chk("halt_held", 24'(MODE_HALT), 24'(mode_state));
    do_reset();
    chk("wdg_clear", 24'h0, 24'(wdr));
    wdg_en = 1'b0;
    test_done();
  end
endmodule // test_interrupt_vector_wakeup_control
